//--- via_pkg.sv
package via_pkg;

  localparam int          NUM_SRC      = 20;
  localparam int          IDX_W        = 5;
  localparam int          VEC_W        = 16;
  localparam int          NUM_PIN      = 2;
  localparam int          CALL_CYCLES  = 4;

  // Timer control bit positions.
  localparam int          TC_TYPE0_BIT = 0;
  localparam int          TC_PEND0_BIT = 1;
  localparam int          TC_TYPE1_BIT = 2;
  localparam int          TC_PEND1_BIT = 3;
  localparam logic [3:0]  TC_RESET     = 4'h0;

  // Register reset values and global enable position.
  localparam logic [7:0]  EN_RESET     = 8'h00;
  localparam logic [7:0]  LVL_RESET    = 8'h00;
  localparam int          GIE_BIT      = 7;

  // Register write selects.
  localparam logic [2:0]  SEL_EN_BASE  = 3'h0;
  localparam logic [2:0]  SEL_EN_EXT1  = 3'h1;
  localparam logic [2:0]  SEL_EN_SEC   = 3'h2;
  localparam logic [2:0]  SEL_LV_BASE  = 3'h3;
  localparam logic [2:0]  SEL_LV_EXT1  = 3'h4;
  localparam logic [2:0]  SEL_LV_SEC   = 3'h5;

  // Source index ranges per register group and pin source indices.
  localparam int          EXT1_FIRST   = 6;
  localparam int          SEC_FIRST    = 13;
  localparam int          SRC_PIN0     = 0;
  localparam int          SRC_PIN1     = 2;

  // Vectors in fixed rank order; index is the arbitration position.
  localparam logic [VEC_W-1:0] VEC_TABLE [NUM_SRC] = '{
    16'h0003, 16'h000b, 16'h0013, 16'h001b, 16'h0023, 16'h002b, 16'h0033,
    16'h003b, 16'h0043, 16'h004b, 16'h0053, 16'h005b, 16'h0063, 16'h0073,
    16'h007b, 16'h0083, 16'h0093, 16'h008b, 16'h009b, 16'h00a3};

  typedef enum logic [4:0] {
    ST_IDLE    = 5'h01,
    ST_PUSH_LO = 5'h02,
    ST_PUSH_HI = 5'h04,
    ST_FETCH   = 5'h08,
    ST_LOAD    = 5'h10
  } via_state_t;

endpackage

//--- via_vec_rom.sv
`timescale 1ns/10ps
// Vector lookup with registered read data.
module via_vec_rom
  import via_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [IDX_W-1:0] addr,
  output logic      [VEC_W-1:0] data_r
);

  // Read one vector per clock; out of range reads the first entry.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      data_r <= '0;
    end else if (addr < IDX_W'(NUM_SRC)) begin
      data_r <= VEC_TABLE[addr];
    end else begin
      data_r <= VEC_TABLE[0];
    end
  end

endmodule

//--- via_arbiter.sv
`timescale 1ns/10ps
// Interrupt arbiter: pending flags, masking, two-level arbitration and call sequencing.
module via_arbiter
  import via_pkg::*;
(
  input  wire logic               CLK,
  input  wire logic               RST_N,
  input  wire logic               EXT_REQ_PIN_ZERO_N,
  input  wire logic               EXT_REQ_PIN_ONE_N,
  input  wire logic [NUM_SRC-1:0] PERIPH_PEND,
  input  wire logic               TIMER_CTRL_WR,
  input  wire logic [3:0]         TIMER_CTRL_WDATA,
  input  wire logic               REG_WR,
  input  wire logic [2:0]         REG_WR_SEL,
  input  wire logic [7:0]         REG_WR_DATA,
  input  wire logic               INSTR_BOUNDARY,
  input  wire logic               RETURN_DONE,
  output logic [3:0]              TIMER_CTRL_REG,
  output logic [7:0]              ENABLE_REG_BASE,
  output logic [7:0]              ENABLE_REG_EXT1,
  output logic [7:0]              ENABLE_REG_SECOND,
  output logic [7:0]              LEVEL_REG_BASE,
  output logic [7:0]              LEVEL_REG_EXT1,
  output logic [7:0]              LEVEL_REG_SECOND,
  output logic                    CALL_START,
  output logic                    PUSH_RET_LO,
  output logic                    PUSH_RET_HI,
  output logic                    PC_LOAD,
  output logic [VEC_W-1:0]        VECTOR_ADDR,
  output logic                    CALL_BUSY,
  output logic                    IN_SERVICE_LOW,
  output logic                    IN_SERVICE_HIGH
);

  logic [NUM_PIN-1:0] pin_n;
  logic [NUM_PIN-1:0] pin_s1_r;
  logic [NUM_PIN-1:0] pin_s2_r;
  logic [NUM_PIN-1:0] pin_d_r;
  logic [NUM_PIN-1:0] fall;
  logic [NUM_PIN-1:0] type_sel;
  logic [NUM_PIN-1:0] vec_clr;
  logic [3:0]         tctrl_r;
  logic [7:0]         en_base_r;
  logic [7:0]         en_ext1_r;
  logic [7:0]         en_sec_r;
  logic [7:0]         lv_base_r;
  logic [7:0]         lv_ext1_r;
  logic [7:0]         lv_sec_r;
  logic [NUM_SRC-1:0] pend;
  logic [NUM_SRC-1:0] en_vec;
  logic [NUM_SRC-1:0] lv_vec;
  logic [NUM_SRC-1:0] elig;
  logic [NUM_SRC-1:0] cand_hi;
  logic [NUM_SRC-1:0] cand_lo;
  logic [NUM_SRC-1:0] cand;
  logic               allow_lo;
  logic               allow_hi;
  logic               act_hi_eff;
  logic               act_lo_eff;
  logic               req_nxt;
  logic               win_hi_nxt;
  logic [IDX_W-1:0]   win_idx_nxt;
  logic               req_r;
  logic               win_hi_r;
  logic [IDX_W-1:0]   win_idx_r;
  logic [VEC_W-1:0]   rom_data;
  logic               take;
  logic               act_lo_r;
  logic               act_hi_r;
  logic [VEC_W-1:0]   vec_r;
  via_state_t         state_r;
  via_state_t         state_nxt;

  assign pin_n = {EXT_REQ_PIN_ONE_N, EXT_REQ_PIN_ZERO_N};
  assign type_sel = {tctrl_r[TC_TYPE1_BIT], tctrl_r[TC_TYPE0_BIT]};

  // Two-stage synchronisers on the request pins, then a delayed copy for edges.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      pin_s1_r <= '1;
      pin_s2_r <= '1;
      pin_d_r  <= '1;
    end else begin
      pin_s1_r <= pin_n;
      pin_s2_r <= pin_s1_r;
      pin_d_r  <= pin_s2_r;
    end
  end

  // Falling edge of an active-low pin, and the hardware clear on vectoring.
  genvar p;
  generate
    for (p = 0; p < NUM_PIN; p++) begin : g_pin
      assign fall[p] = pin_d_r[p] & ~pin_s2_r[p];
      assign vec_clr[p] = take & type_sel[p]
                          & (win_idx_r == IDX_W'(p == 0 ? SRC_PIN0 : SRC_PIN1));
    end
  endgenerate

  // Timer control: type bits from software, pending bits from pins or software.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      tctrl_r <= TC_RESET;
    end else begin
      if (TIMER_CTRL_WR) begin
        tctrl_r[TC_TYPE0_BIT] <= TIMER_CTRL_WDATA[TC_TYPE0_BIT];
        tctrl_r[TC_TYPE1_BIT] <= TIMER_CTRL_WDATA[TC_TYPE1_BIT];
      end
      // Pin zero flag: tracks the pin in level mode, latches edges otherwise.
      if (!type_sel[0]) begin
        tctrl_r[TC_PEND0_BIT] <= ~pin_s2_r[0];
      end else if (fall[0]) begin
        tctrl_r[TC_PEND0_BIT] <= 1'b1;
      end else if (vec_clr[0]) begin
        tctrl_r[TC_PEND0_BIT] <= 1'b0;
      end else if (TIMER_CTRL_WR) begin
        tctrl_r[TC_PEND0_BIT] <= TIMER_CTRL_WDATA[TC_PEND0_BIT];
      end
      // Pin one flag, same scheme.
      if (!type_sel[1]) begin
        tctrl_r[TC_PEND1_BIT] <= ~pin_s2_r[1];
      end else if (fall[1]) begin
        tctrl_r[TC_PEND1_BIT] <= 1'b1;
      end else if (vec_clr[1]) begin
        tctrl_r[TC_PEND1_BIT] <= 1'b0;
      end else if (TIMER_CTRL_WR) begin
        tctrl_r[TC_PEND1_BIT] <= TIMER_CTRL_WDATA[TC_PEND1_BIT];
      end
    end
  end

  // Enable and level registers; level bits reset to the low level.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      en_base_r <= EN_RESET;
      en_ext1_r <= EN_RESET;
      en_sec_r  <= EN_RESET;
      lv_base_r <= LVL_RESET;
      lv_ext1_r <= LVL_RESET;
      lv_sec_r  <= LVL_RESET;
    end else if (REG_WR) begin
      case (REG_WR_SEL)
        SEL_EN_BASE: en_base_r <= REG_WR_DATA;
        SEL_EN_EXT1: en_ext1_r <= REG_WR_DATA;
        SEL_EN_SEC:  en_sec_r  <= REG_WR_DATA;
        SEL_LV_BASE: lv_base_r <= REG_WR_DATA;
        SEL_LV_EXT1: lv_ext1_r <= REG_WR_DATA;
        SEL_LV_SEC:  lv_sec_r  <= REG_WR_DATA;
        default: ;
      endcase
    end
  end

  // Per-source pending, enable and level bits mapped from the register groups.
  genvar i;
  generate
    for (i = 0; i < NUM_SRC; i++) begin : g_src
      if (i == SRC_PIN0) begin : g_p0
        assign pend[i] = tctrl_r[TC_PEND0_BIT];
      end else if (i == SRC_PIN1) begin : g_p1
        assign pend[i] = tctrl_r[TC_PEND1_BIT];
      end else begin : g_per
        assign pend[i] = PERIPH_PEND[i];
      end
      if (i < EXT1_FIRST) begin : g_base
        assign en_vec[i] = en_base_r[i];
        assign lv_vec[i] = lv_base_r[i];
      end else if (i < SEC_FIRST) begin : g_ext1
        assign en_vec[i] = en_ext1_r[i-EXT1_FIRST];
        assign lv_vec[i] = lv_ext1_r[i-EXT1_FIRST];
      end else begin : g_sec
        assign en_vec[i] = en_sec_r[i-SEC_FIRST];
        assign lv_vec[i] = lv_sec_r[i-SEC_FIRST];
      end
    end
  endgenerate

  // Masking and preemption: a high routine blocks all, a low routine admits high only.
  assign elig     = pend & en_vec & {NUM_SRC{en_base_r[GIE_BIT]}};
  // A return in its last cycle already frees its level, so that only one
  // instruction runs between the return and the next call.
  assign act_hi_eff = act_hi_r & ~RETURN_DONE;
  assign act_lo_eff = act_lo_r & ~(RETURN_DONE & ~act_hi_r);
  assign allow_hi   = ~act_hi_eff;
  assign allow_lo   = ~act_hi_eff & ~act_lo_eff;
  assign cand_hi  = elig & lv_vec & {NUM_SRC{allow_hi}};
  assign cand_lo  = elig & ~lv_vec & {NUM_SRC{allow_lo}};
  assign cand     = (|cand_hi) ? cand_hi : cand_lo;

  // Lowest index among the winning level.
  always_comb begin
    win_idx_nxt = '0;
    for (int k = NUM_SRC - 1; k >= 0; k--) begin
      if (cand[k]) begin
        win_idx_nxt = IDX_W'(k);
      end
    end
    req_nxt    = |cand;
    win_hi_nxt = |cand_hi;
  end

  // Detect stage: sampled and decoded on every clock.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      req_r     <= 1'b0;
      win_hi_r  <= 1'b0;
      win_idx_r <= '0;
    end else begin
      req_r     <= req_nxt & ~take;
      win_hi_r  <= win_hi_nxt;
      win_idx_r <= win_idx_nxt;
    end
  end

  via_vec_rom u_rom (
    .clk    (CLK),
    .rst_n  (RST_N),
    .addr   (win_idx_nxt),
    .data_r (rom_data)
  );

  // Call only at a boundary that is not the end of a return instruction.
  assign take = (state_r == ST_IDLE) & INSTR_BOUNDARY & req_r & ~RETURN_DONE;

  // Four-clock call sequence.
  always_comb begin
    case (state_r)
      ST_IDLE:    state_nxt = take ? ST_PUSH_LO : ST_IDLE;
      ST_PUSH_LO: state_nxt = ST_PUSH_HI;
      ST_PUSH_HI: state_nxt = ST_FETCH;
      ST_FETCH:   state_nxt = ST_LOAD;
      ST_LOAD:    state_nxt = ST_IDLE;
      default:    state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Vector captured when the call is taken.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      vec_r <= '0;
    end else if (take) begin
      vec_r <= rom_data;
    end
  end

  // In-service levels: pushed on a call, the highest popped on return.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      act_lo_r <= 1'b0;
      act_hi_r <= 1'b0;
    end else if (take) begin
      if (win_hi_r) begin
        act_hi_r <= 1'b1;
      end else begin
        act_lo_r <= 1'b1;
      end
    end else if (RETURN_DONE) begin
      if (act_hi_r) begin
        act_hi_r <= 1'b0;
      end else begin
        act_lo_r <= 1'b0;
      end
    end
  end

  // Outputs.
  assign CALL_START        = take;
  assign PUSH_RET_LO       = state_r[1];
  assign PUSH_RET_HI       = state_r[2];
  assign PC_LOAD           = state_r[4];
  assign CALL_BUSY         = ~state_r[0];
  assign VECTOR_ADDR       = vec_r;
  assign IN_SERVICE_LOW    = act_lo_r;
  assign IN_SERVICE_HIGH   = act_hi_r;
  assign TIMER_CTRL_REG    = tctrl_r;
  assign ENABLE_REG_BASE   = en_base_r;
  assign ENABLE_REG_EXT1   = en_ext1_r;
  assign ENABLE_REG_SECOND = en_sec_r;
  assign LEVEL_REG_BASE    = lv_base_r;
  assign LEVEL_REG_EXT1    = lv_ext1_r;
  assign LEVEL_REG_SECOND  = lv_sec_r;

  // Checks.
  sequence s_call_steps;
    PUSH_RET_LO ##1 PUSH_RET_HI ##1 (!PC_LOAD && CALL_BUSY) ##1 PC_LOAD;
  endsequence

  property p_call_len;
    @(posedge CLK) disable iff (!RST_N) take |=> s_call_steps ##1 !CALL_BUSY;
  endproperty
  a_call_len: assert property (p_call_len) else $error("call not four clocks");

  property p_no_call_on_return;
    @(posedge CLK) disable iff (!RST_N) RETURN_DONE |-> !CALL_START;
  endproperty
  a_no_call_on_return: assert property (p_no_call_on_return) else $error("call on return");

  property p_gie_blocks;
    @(posedge CLK) disable iff (!RST_N) !en_base_r[GIE_BIT] |=> !req_r;
  endproperty
  a_gie_blocks: assert property (p_gie_blocks) else $error("request with global off");

  property p_edge_clear;
    @(posedge CLK) disable iff (!RST_N)
      (vec_clr[0] && !fall[0] && type_sel[0]) |=> !tctrl_r[TC_PEND0_BIT];
  endproperty
  a_edge_clear: assert property (p_edge_clear) else $error("edge flag not cleared");

  property p_level_track;
    @(posedge CLK) disable iff (!RST_N)
      !type_sel[1] |=> tctrl_r[TC_PEND1_BIT] == !$past(pin_s2_r[1]);
  endproperty
  a_level_track: assert property (p_level_track) else $error("level flag not tracking");

  property p_high_no_preempt;
    @(posedge CLK) disable iff (!RST_N) act_hi_r |-> !take;
  endproperty
  a_high_no_preempt: assert property (p_high_no_preempt) else $error("high preempted");

  property p_high_first;
    @(posedge CLK) disable iff (!RST_N) (|cand_hi) |=> win_hi_r && req_r || $past(take);
  endproperty
  a_high_first: assert property (p_high_first) else $error("low served before high");

  property p_fixed_order;
    @(posedge CLK) disable iff (!RST_N) cand[0] |=> win_idx_r == '0;
  endproperty
  a_fixed_order: assert property (p_fixed_order) else $error("rank zero not chosen");

  property p_vector_load;
    @(posedge CLK) disable iff (!RST_N)
      take |-> ##4 (PC_LOAD && VECTOR_ADDR == VEC_TABLE[$past(win_idx_r, 4)]);
  endproperty
  a_vector_load: assert property (p_vector_load) else $error("wrong vector loaded");

endmodule

//--- via_cpu_model.sv
`timescale 1ns/10ps
// Sequencer stand-in: marks instruction ends and the end of each return.
module via_cpu_model
  import via_pkg::*;
(
  input  wire logic       CLK,
  input  wire logic       RST_N,
  input  wire logic       CALL_BUSY,
  input  wire logic       RET_REQ,
  input  wire logic [3:0] INSTR_LEN,
  output logic            INSTR_BOUNDARY,
  output logic            RETURN_DONE
);
  logic [3:0] cnt_r;
  logic [3:0] len_r;
  logic       ret_r;
  logic       last;

  // No boundary while a call runs, so a vector only lands at a real instruction end.
  assign last           = (cnt_r == len_r - 4'h1);
  assign INSTR_BOUNDARY = last && !CALL_BUSY;
  assign RETURN_DONE    = INSTR_BOUNDARY && ret_r;

  // A return lasts five clocks; other lengths come from the bench, eight for a divide.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cnt_r <= 4'h0;
      len_r <= 4'h1;
      ret_r <= 1'b0;
    end else if (CALL_BUSY) begin
      cnt_r <= 4'h0;
    end else if (last) begin
      cnt_r <= 4'h0;
      ret_r <= RET_REQ;
      len_r <= RET_REQ ? 4'h5 : INSTR_LEN;
    end else begin
      cnt_r <= cnt_r + 4'h1;
    end
  end
endmodule

//--- vectored_interrupt_arbiter_tb_top.sv
`timescale 1ns/10ps
// Self-checking bench for the interrupt arbiter.
module vectored_interrupt_arbiter_tb_top
  import via_pkg::*;
;
  logic               clk;
  logic               rst_n;
  logic               pin0_n;
  logic               pin1_n;
  logic [NUM_SRC-1:0] pend;
  logic               tc_wr;
  logic [3:0]         tc_wd;
  logic               reg_wr;
  logic [2:0]         sel;
  logic [7:0]         wd;
  logic               ret_req;
  logic [3:0]         ilen;
  logic               bnd;
  logic               ret_done;
  logic [3:0]         tc_reg;
  logic [7:0]         en_b;
  logic [7:0]         en_e;
  logic [7:0]         en_s;
  logic [7:0]         lv_b;
  logic [7:0]         lv_e;
  logic [7:0]         lv_s;
  logic               call_start;
  logic               push_lo;
  logic               push_hi;
  logic               pc_load;
  logic [VEC_W-1:0]   vec;
  logic               busy;
  logic               isl;
  logic               ish;
  int                 bad_count;
  int                 num_checks;
  int                 n;

  via_arbiter u_dut (.CLK(clk), .RST_N(rst_n), .EXT_REQ_PIN_ZERO_N(pin0_n),
    .EXT_REQ_PIN_ONE_N(pin1_n), .PERIPH_PEND(pend), .TIMER_CTRL_WR(tc_wr),
    .TIMER_CTRL_WDATA(tc_wd), .REG_WR(reg_wr), .REG_WR_SEL(sel), .REG_WR_DATA(wd),
    .INSTR_BOUNDARY(bnd), .RETURN_DONE(ret_done), .TIMER_CTRL_REG(tc_reg),
    .ENABLE_REG_BASE(en_b), .ENABLE_REG_EXT1(en_e), .ENABLE_REG_SECOND(en_s),
    .LEVEL_REG_BASE(lv_b), .LEVEL_REG_EXT1(lv_e), .LEVEL_REG_SECOND(lv_s),
    .CALL_START(call_start), .PUSH_RET_LO(push_lo), .PUSH_RET_HI(push_hi),
    .PC_LOAD(pc_load), .VECTOR_ADDR(vec), .CALL_BUSY(busy),
    .IN_SERVICE_LOW(isl), .IN_SERVICE_HIGH(ish));

  via_cpu_model u_cpu (.CLK(clk), .RST_N(rst_n), .CALL_BUSY(busy), .RET_REQ(ret_req),
    .INSTR_LEN(ilen), .INSTR_BOUNDARY(bnd), .RETURN_DONE(ret_done));

  // Free-running clock at 200 MHz.
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Prints the verdict and ends the run.
  task automatic summarize();
    if (bad_count == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Compares a value with its expectation and reports a difference.
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Single-bit form of the comparison.
  task automatic chkb(input string nm, input logic e, input logic g);
    chk(nm, {15'h0, e}, {15'h0, g});
  endtask

  // One-cycle write strobes on the register and timer control ports.
  task automatic wr(input logic [2:0] s, input logic [7:0] d);
    @(negedge clk);
    reg_wr = 1'b1;
    sel    = s;
    wd     = d;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask

  task automatic tcw(input logic [3:0] d);
    @(negedge clk);
    tc_wr = 1'b1;
    tc_wd = d;
    @(negedge clk);
    tc_wr = 1'b0;
  endtask

  // Waits for a call, then follows its four clocks step by step.
  task automatic wait_call(input logic [15:0] v, output int k);
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (call_start !== 1'b1 && k < 40);
    if (k >= 40) begin
      bad_count++;
      summarize();
    end
    @(negedge clk);
    chkb("push_lo", 1'b1, push_lo);
    chk("vector", v, vec);
    @(negedge clk);
    chkb("push_hi", 1'b1, push_hi);
    @(negedge clk);
    chkb("busy", 1'b1, busy);
    @(negedge clk);
    chkb("pc_load", 1'b1, pc_load);
    @(negedge clk);
    chkb("busy", 1'b0, busy);
  endtask

  // Checks that no call starts for a number of cycles.
  task automatic no_call(input int c);
    repeat (c) begin
      @(negedge clk);
      chkb("call_start", 1'b0, call_start);
    end
  endtask

  // Runs one return instruction; no call may start in its last cycle.
  task automatic do_ret();
    int k;
    k = 0;
    ret_req = 1'b1;
    do begin
      @(negedge clk);
      k++;
    end while (ret_done !== 1'b1 && k < 40);
    ret_req = 1'b0;
    if (k >= 40) begin
      bad_count++;
      summarize();
    end
    chkb("call_start", 1'b0, call_start);
  endtask

  task automatic t_reset();
    chk("regs", 16'h0, {tc_reg, en_b, 4'h0});
    chk("levels", 16'h0, {lv_b, lv_e | lv_s});
    chkb("service", 1'b0, isl | ish | busy);
  endtask

  task automatic t_global();
    wr(SEL_EN_BASE, 8'h20);
    pend[5] = 1'b1;
    no_call(8);
    wr(SEL_EN_BASE, 8'ha0);
    wait_call(16'h002b, n);
    pend[5] = 1'b0;
    chkb("low", 1'b1, isl);
    do_ret();
    @(negedge clk);
    chkb("low", 1'b0, isl);
  endtask

  task automatic t_table();
    wr(SEL_EN_BASE, 8'hff);
    wr(SEL_EN_EXT1, 8'h7f);
    wr(SEL_EN_SEC, 8'h7f);
    for (int i = 0; i < NUM_SRC; i++) begin
      if (i != SRC_PIN0 && i != SRC_PIN1) begin
        pend[i] = 1'b1;
        wait_call(VEC_TABLE[i], n);
        chk("latency", 16'h1, n[15:0]);
        pend[i] = 1'b0;
        do_ret();
      end
    end
  endtask

  task automatic t_order();
    pend[3]  = 1'b1;
    pend[14] = 1'b1;
    wait_call(16'h001b, n);
    pend[3] = 1'b0;
    do_ret();
    wait_call(16'h007b, n);
    chk("again", 16'h1, n[15:0]);
    pend[14] = 1'b0;
    do_ret();
    wr(SEL_LV_SEC, 8'h02);
    pend[3]  = 1'b1;
    pend[14] = 1'b1;
    wait_call(16'h007b, n);
    pend = '0;
    do_ret();
    wr(SEL_LV_SEC, 8'h00);
  endtask

  task automatic t_preempt();
    pend[4] = 1'b1;
    wait_call(16'h0023, n);
    pend[4] = 1'b0;
    wr(SEL_LV_BASE, 8'h0a);
    pend[1] = 1'b1;
    wait_call(16'h000b, n);
    pend[1] = 1'b0;
    chkb("high", 1'b1, ish);
    pend[3] = 1'b1;
    no_call(10);
    ilen = 4'h8;
    do_ret();
    wait_call(16'h001b, n);
    chk("after_ret", 16'h8, n[15:0]);
    ilen    = 4'h1;
    pend[3] = 1'b0;
    do_ret();
    @(negedge clk);
    do_ret();
    wr(SEL_LV_BASE, 8'h00);
  endtask

  task automatic t_pins();
    wr(SEL_EN_BASE, 8'h80);
    tcw(4'h1);
    pin0_n = 1'b0;
    repeat (4) @(negedge clk);
    chkb("pend0", 1'b1, tc_reg[TC_PEND0_BIT]);
    pin0_n = 1'b1;
    no_call(4);
    chkb("pend0", 1'b1, tc_reg[TC_PEND0_BIT]);
    wr(SEL_EN_BASE, 8'h81);
    wait_call(16'h0003, n);
    chkb("pend0", 1'b0, tc_reg[TC_PEND0_BIT]);
    do_ret();
    pin1_n = 1'b0;
    repeat (4) @(negedge clk);
    chkb("pend1", 1'b1, tc_reg[TC_PEND1_BIT]);
    pin1_n = 1'b1;
    repeat (4) @(negedge clk);
    chkb("pend1", 1'b0, tc_reg[TC_PEND1_BIT]);
    wr(SEL_EN_BASE, 8'h85);
    pin1_n = 1'b0;
    wait_call(16'h0013, n);
    pin1_n = 1'b1;
    do_ret();
    no_call(6);
    tcw(4'h4);
    pin1_n = 1'b0;
    wait_call(16'h0013, n);
    chkb("pend1", 1'b0, tc_reg[TC_PEND1_BIT]);
    pin1_n = 1'b1;
    do_ret();
  endtask

  // Main sequence: reset for two cycles, then every scenario in turn.
  initial begin
    bad_count  = 0;
    num_checks = 0;
    rst_n      = 1'b0;
    pin0_n     = 1'b1;
    pin1_n     = 1'b1;
    pend       = '0;
    tc_wr      = 1'b0;
    tc_wd      = 4'h0;
    reg_wr     = 1'b0;
    sel        = 3'h0;
    wd         = 8'h00;
    ret_req    = 1'b0;
    ilen       = 4'h1;
    repeat (2) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    t_reset();
    t_global();
    t_table();
    t_order();
    t_preempt();
    t_pins();
    summarize();
  end
endmodule
